// >>> logic/lsrs_top.sv
// Rail sequencer, colour strobe decoder and register slave
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Request high: init mirrors, offset rail soon
// - Bias and reset rails 145 ms later
// - Strobe and LED driver off until rails
// - Request low runs timed normal power-down
// - Any rail fault: discharge all rails together
// - Select code closes one switch or none
// - Route selected switch's current code onward
// - Open old switches before closing new ones
// - Dead time equals programmed gap register, at least one cycle
// - Switch staying closed is never opened
// - Power request filtered for about 1 ms
// - Colour select filtered for about 300 ns
////////////////////////////////////////////////////////////////////////////////
module lsrs_top #(
  parameter int unsigned OFS_DLY_US   = lsrs_pkg::T_OFS_DLY_US, // Ticks
  parameter int unsigned RAIL_DLY_US  = lsrs_pkg::RAIL_DLY_US,  // Ticks
  parameter int unsigned PD_DLY_US    = lsrs_pkg::T_PD_DLY_US,  // Ticks
  parameter int unsigned PROJ_DGL_CYC = lsrs_pkg::PROJ_DGL_CYC  // Cycles
) (
  input  wire logic        core_clk,                // 25 MHz clock
  input  wire logic        sys_rst,                 // Sync reset, high
  input  wire logic        projector_power_request, // Power request pin
  input  wire logic [1:0]  colour_select,           // Colour select pins
  input  wire logic [2:0]  rail_fault,              // Rail fault flags
  input  wire logic [4:0]  avs_address,             // Byte address
  input  wire logic        avs_read,                // Read request
  input  wire logic        avs_write,               // Write request
  input  wire logic [31:0] avs_writedata,           // Write data
  input  wire logic [3:0]  avs_byteenable,          // Byte lanes
  output logic      [31:0] avs_readdata,            // Read data
  output logic             avs_waitrequest,         // Stall, high
  output logic             mirror_init,             // Mirror init phase
  output logic             offset_rail_en,          // Offset rail on
  output logic             bias_rail_en,            // Bias rail on
  output logic             reset_rail_en,           // Reset rail on
  output logic             rail_discharge,          // Fast discharge
  output logic             led_driver_en,           // LED driver enable
  output logic             switch_a,                // Switch a closed
  output logic             switch_b,                // Switch b closed
  output logic             switch_c,                // Switch c closed
  output logic      [9:0]  led_current_code         // Code to current loop
);

  localparam int unsigned DW = lsrs_pkg::DLY_W;
  localparam int unsigned TW = lsrs_pkg::DIV_W;

  // Every check below runs on the core clock and sleeps during reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Filtered pins
  logic                  req_clean;
  logic [1:0]            sel_clean;

  // Register file and bus state
  logic                  wreq_ff, nxt_wreq;
  logic [31:0]           rdata_ff, nxt_rdata;
  logic [2:0]            swctl_ff, nxt_swctl;
  logic [7:0]            gap_ff, nxt_gap;
  logic [9:0]            code_a_ff, nxt_code_a;
  logic [9:0]            code_b_ff, nxt_code_b;
  logic [9:0]            code_c_ff, nxt_code_c;
  logic                  fault_seen_ff, nxt_fault_seen;
  logic                  wr_commit;
  logic [31:0]           wr_word;

  // Sequencer state
  lsrs_pkg::lsrs_state_e state_ff, nxt_state;
  logic [DW-1:0]         dly_ff, nxt_dly;
  logic [TW-1:0]         div_ff, nxt_div;
  logic                  tick_ff, nxt_tick;
  logic                  init_ff, nxt_init;
  logic                  ofs_ff, nxt_ofs;
  logic                  bias_ff, nxt_bias;
  logic                  rst_ff, nxt_rst;
  logic                  dis_ff, nxt_dis;
  logic                  strobe_ff, nxt_strobe;
  logic                  dly_done;

  // Strobe state
  logic [2:0]            sw_ff, nxt_sw;
  logic [2:0]            target;
  logic [7:0]            gap_cnt_ff, nxt_gap_cnt;
  logic                  gap_wait_ff, nxt_gap_wait;
  logic [9:0]            code_ff, nxt_code;

  // Merge write data into a register through the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin filters
  lsrs_deglitch #(.W(1), .CNT(PROJ_DGL_CYC)) u_req_dgl (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (projector_power_request),
    .dout     (req_clean)
  );

  lsrs_deglitch #(.W(2), .CNT(lsrs_pkg::SEL_DGL_CYC)) u_sel_dgl (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (colour_select),
    .dout     (sel_clean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then answer; unmapped reads give zero
  always_comb begin
    nxt_wreq       = 1'b1;
    nxt_rdata      = rdata_ff;
    nxt_swctl      = swctl_ff;
    nxt_gap        = gap_ff;
    wr_word        = 32'h0000_0000;
    nxt_code_a     = code_a_ff;
    nxt_code_b     = code_b_ff;
    nxt_code_c     = code_c_ff;
    wr_commit      = avs_write && !wreq_ff;
    // Hardware set wins over a software clear in the same cycle
    nxt_fault_seen = fault_seen_ff;
    if (wr_commit && avs_address == lsrs_pkg::OFF_STATUS &&
        avs_byteenable[1] && avs_writedata[lsrs_pkg::STS_FAULT]) begin
      nxt_fault_seen = 1'b0;
    end
    if (nxt_state inside {lsrs_pkg::ST_FAST_PREP, lsrs_pkg::ST_FAST} &&
        !(state_ff inside {lsrs_pkg::ST_FAST_PREP, lsrs_pkg::ST_FAST})) begin
      nxt_fault_seen = 1'b1;
    end
    if ((avs_read || avs_write) && wreq_ff) begin
      nxt_wreq = 1'b0;
    end
    if (avs_read && wreq_ff) begin
      nxt_rdata = 32'h0000_0000;
      unique case (avs_address)
        lsrs_pkg::OFF_SWCTL:  nxt_rdata[2:0] = swctl_ff;
        lsrs_pkg::OFF_GAP:    nxt_rdata[7:0] = gap_ff;
        lsrs_pkg::OFF_CODE_A: nxt_rdata[9:0] = code_a_ff;
        lsrs_pkg::OFF_CODE_B: nxt_rdata[9:0] = code_b_ff;
        lsrs_pkg::OFF_CODE_C: nxt_rdata[9:0] = code_c_ff;
        lsrs_pkg::OFF_STATUS: begin
          nxt_rdata[lsrs_pkg::STS_STATE_LSB +: 3] = state_ff;
          nxt_rdata[lsrs_pkg::STS_OFS]            = ofs_ff;
          nxt_rdata[lsrs_pkg::STS_BIAS]           = bias_ff;
          nxt_rdata[lsrs_pkg::STS_RST]            = rst_ff;
          nxt_rdata[lsrs_pkg::STS_STROBE]         = strobe_ff;
          nxt_rdata[lsrs_pkg::STS_SW_LSB +: 3]    = sw_ff;
          nxt_rdata[lsrs_pkg::STS_FAULT]          = fault_seen_ff;
          nxt_rdata[lsrs_pkg::STS_RAIL_LSB +: 3]  = rail_fault;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (wr_commit) begin
      unique case (avs_address)
        lsrs_pkg::OFF_SWCTL: begin
          wr_word   = be_merge(32'(swctl_ff), avs_writedata, avs_byteenable);
          nxt_swctl = wr_word[2:0];
        end
        lsrs_pkg::OFF_GAP: begin
          wr_word = be_merge(32'(gap_ff), avs_writedata, avs_byteenable);
          nxt_gap = wr_word[7:0];
        end
        lsrs_pkg::OFF_CODE_A: begin
          wr_word    = be_merge(32'(code_a_ff), avs_writedata, avs_byteenable);
          nxt_code_a = wr_word[9:0];
        end
        lsrs_pkg::OFF_CODE_B: begin
          wr_word    = be_merge(32'(code_b_ff), avs_writedata, avs_byteenable);
          nxt_code_b = wr_word[9:0];
        end
        lsrs_pkg::OFF_CODE_C: begin
          wr_word    = be_merge(32'(code_c_ff), avs_writedata, avs_byteenable);
          nxt_code_c = wr_word[9:0];
        end
        default: nxt_swctl = swctl_ff;
      endcase
    end
  end

  // Bus and register file flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wreq_ff       <= 1'b1;
      rdata_ff      <= 32'h0000_0000;
      swctl_ff      <= lsrs_pkg::SWCTL_RST;
      gap_ff        <= lsrs_pkg::GAP_RST;
      code_a_ff     <= lsrs_pkg::CODE_RST;
      code_b_ff     <= lsrs_pkg::CODE_RST;
      code_c_ff     <= lsrs_pkg::CODE_RST;
      fault_seen_ff <= 1'b0;
    end else begin
      wreq_ff       <= nxt_wreq;
      rdata_ff      <= nxt_rdata;
      swctl_ff      <= nxt_swctl;
      gap_ff        <= nxt_gap;
      code_a_ff     <= nxt_code_a;
      code_b_ff     <= nxt_code_b;
      code_c_ff     <= nxt_code_c;
      fault_seen_ff <= nxt_fault_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail sequencer; delays run on a 1 us tick from the core clock
  always_comb begin
    nxt_tick  = (div_ff == TW'(lsrs_pkg::TICK_CYC - 1));
    nxt_div   = nxt_tick ? '0 : div_ff + TW'(1);
    dly_done  = (dly_ff == '0);
    nxt_state = state_ff;
    nxt_dly   = (tick_ff && !dly_done) ? dly_ff - DW'(1) : dly_ff;
    unique case (state_ff)
      lsrs_pkg::ST_OFF: if (req_clean) begin
        nxt_state = lsrs_pkg::ST_INIT;
        nxt_dly   = DW'(OFS_DLY_US);
      end
      lsrs_pkg::ST_INIT: if (!req_clean) begin
        nxt_state = lsrs_pkg::ST_OFF;
      end else if (dly_done) begin
        nxt_state = lsrs_pkg::ST_OFS;
        nxt_dly   = DW'(RAIL_DLY_US);
      end
      lsrs_pkg::ST_OFS: if (|rail_fault) begin
        nxt_state = lsrs_pkg::ST_FAST_PREP;
      end else if (!req_clean) begin
        nxt_state = lsrs_pkg::ST_PD_PREP;
      end else if (dly_done) begin
        nxt_state = lsrs_pkg::ST_ON;
      end
      lsrs_pkg::ST_ON: if (|rail_fault) begin
        nxt_state = lsrs_pkg::ST_FAST_PREP;
      end else if (!req_clean) begin
        nxt_state = lsrs_pkg::ST_PD_PREP;
      end
      // Rails wait here until every switch has opened
      lsrs_pkg::ST_PD_PREP: if (sw_ff == 3'h0) begin
        nxt_state = lsrs_pkg::ST_PD;
        nxt_dly   = DW'(PD_DLY_US);
      end
      lsrs_pkg::ST_PD: if (|rail_fault) begin
        nxt_state = lsrs_pkg::ST_FAST;
      end else if (dly_done) begin
        nxt_state = lsrs_pkg::ST_OFF;
      end
      lsrs_pkg::ST_FAST_PREP: if (sw_ff == 3'h0) begin
        nxt_state = lsrs_pkg::ST_FAST;
      end
      // Held discharged until the request is withdrawn
      lsrs_pkg::ST_FAST: if (!req_clean) begin
        nxt_state = lsrs_pkg::ST_OFF;
      end
    endcase
    // Outputs follow the next state so they come straight off flops
    nxt_init   = (nxt_state == lsrs_pkg::ST_INIT);
    nxt_ofs    = nxt_state inside {lsrs_pkg::ST_OFS, lsrs_pkg::ST_ON,
                   lsrs_pkg::ST_PD_PREP, lsrs_pkg::ST_PD,
                   lsrs_pkg::ST_FAST_PREP};
    nxt_bias   = (nxt_state == lsrs_pkg::ST_ON) || (bias_ff &&
                 nxt_state inside {lsrs_pkg::ST_PD_PREP,
                   lsrs_pkg::ST_FAST_PREP});
    nxt_rst    = nxt_bias;
    nxt_dis    = (nxt_state == lsrs_pkg::ST_FAST);
    nxt_strobe = (nxt_state == lsrs_pkg::ST_ON);
  end

  // Sequencer flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff  <= lsrs_pkg::ST_OFF;
      dly_ff    <= '0;
      div_ff    <= '0;
      tick_ff   <= 1'b0;
      init_ff   <= 1'b0;
      ofs_ff    <= 1'b0;
      bias_ff   <= 1'b0;
      rst_ff    <= 1'b0;
      dis_ff    <= 1'b0;
      strobe_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      dly_ff    <= nxt_dly;
      div_ff    <= nxt_div;
      tick_ff   <= nxt_tick;
      init_ff   <= nxt_init;
      ofs_ff    <= nxt_ofs;
      bias_ff   <= nxt_bias;
      rst_ff    <= nxt_rst;
      dis_ff    <= nxt_dis;
      strobe_ff <= nxt_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decoder with break-before-make; dead time is max(gap, 1) cycles
  always_comb begin
    target = strobe_ff ? (lsrs_pkg::lsrs_sel_decode(sel_clean) & swctl_ff)
                       : 3'h0;
    nxt_sw       = sw_ff;
    nxt_gap_cnt  = gap_cnt_ff;
    nxt_gap_wait = gap_wait_ff;
    if ((sw_ff & ~target) != 3'h0) begin
      nxt_sw       = sw_ff & target;
      nxt_gap_cnt  = gap_ff;
      nxt_gap_wait = 1'b1;
    end else if (target != sw_ff) begin
      if (!gap_wait_ff || gap_cnt_ff <= 8'h01) begin
        nxt_sw       = target;
        nxt_gap_wait = 1'b0;
      end else begin
        nxt_gap_cnt = gap_cnt_ff - 8'h01;
      end
    end else begin
      nxt_gap_wait = 1'b0;
    end
    // No code is routed while every switch is open
    nxt_code = 10'h000;
    if (nxt_sw[0]) nxt_code = code_a_ff;
    if (nxt_sw[1]) nxt_code = code_b_ff;
    if (nxt_sw[2]) nxt_code = code_c_ff;
  end

  // Strobe flip-flops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sw_ff       <= 3'h0;
      gap_cnt_ff  <= 8'h00;
      gap_wait_ff <= 1'b0;
      code_ff     <= 10'h000;
    end else begin
      sw_ff       <= nxt_sw;
      gap_cnt_ff  <= nxt_gap_cnt;
      gap_wait_ff <= nxt_gap_wait;
      code_ff     <= nxt_code;
    end
  end

  // Outputs, each straight from a flop
  assign avs_readdata     = rdata_ff;
  assign avs_waitrequest  = wreq_ff;
  assign mirror_init      = init_ff;
  assign offset_rail_en   = ofs_ff;
  assign bias_rail_en     = bias_ff;
  assign reset_rail_en    = rst_ff;
  assign rail_discharge   = dis_ff;
  assign led_driver_en    = strobe_ff;
  assign switch_a         = sw_ff[0];
  assign switch_b         = sw_ff[1];
  assign switch_c         = sw_ff[2];
  assign led_current_code = code_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on sequencing and switching
  a_offset_after_init: assert property (
    $rose(ofs_ff) |-> ($past(state_ff) == lsrs_pkg::ST_INIT && $past(init_ff)))
    else $error("offset rail rose without the init phase");
  a_bias_after_delay: assert property (
    $rose(bias_ff) |-> ($past(state_ff) == lsrs_pkg::ST_OFS &&
                        $past(dly_ff) == '0 && rst_ff && ofs_ff))
    else $error("bias rail rose before the delay ran out");
  a_driver_needs_rails: assert property (
    strobe_ff |-> (ofs_ff && bias_ff && rst_ff))
    else $error("LED driver enabled with a rail off");
  a_normal_power_down: assert property (
    (state_ff == lsrs_pkg::ST_ON && !req_clean && rail_fault == 3'h0) |->
      ##[1:3] (state_ff == lsrs_pkg::ST_PD && !bias_ff && ofs_ff))
    else $error("normal power-down did not start");
  a_fast_discharge: assert property (
    (state_ff == lsrs_pkg::ST_ON && rail_fault != 3'h0) |->
      ##[1:3] (dis_ff && !ofs_ff && !bias_ff && !rst_ff))
    else $error("rail fault did not discharge all rails");
  a_switch_decode: assert property (
    (sw_ff != 3'h0) |-> (sw_ff == lsrs_pkg::lsrs_sel_decode($past(sel_clean))))
    else $error("closed switch does not match colour select");
  a_code_routed: assert property (
    (sw_ff == 3'h2) |-> (code_ff == $past(code_b_ff)))
    else $error("switch b closed with a foreign current code");
  a_code_idle: assert property (
    (sw_ff == 3'h0) |-> (code_ff == 10'h000))
    else $error("current code routed with all switches open");
  a_break_first: assert property (
    ((sw_ff & ~$past(sw_ff)) != 3'h0) |-> (($past(sw_ff) & ~sw_ff) == 3'h0))
    else $error("switch opened and closed in the same cycle");
  a_dead_time: assert property (
    ((sw_ff & ~$past(sw_ff)) != 3'h0 && $past(gap_wait_ff)) |->
      ($past(gap_cnt_ff) <= 8'h01))
    else $error("switch closed before the dead time ended");
  a_rails_after_open: assert property (
    ($fell(ofs_ff) || $rose(dis_ff)) |-> (sw_ff == 3'h0 && !strobe_ff))
    else $error("rails went down with a switch still closed");

endmodule

// >>> logic/lsrs_pkg.sv
// Constants, register map, states and decode for the LED strobe sequencer
package lsrs_pkg;

  // Core clock and the microsecond tick divider
  localparam int unsigned CLK_HZ   = 25_000_000;
  localparam int unsigned CLK_MHZ  = CLK_HZ / 1_000_000;
  localparam int unsigned TICK_CYC = CLK_MHZ;
  localparam int unsigned DIV_W    = 5;

  // Rail sequencing times, counted in microsecond ticks
  localparam int unsigned T_OFS_DLY_US  = 5000;
  localparam int unsigned T_RAIL_DLY_MS = 145;
  localparam int unsigned RAIL_DLY_US   = T_RAIL_DLY_MS * 1000;
  localparam int unsigned T_PD_DLY_US   = 100;
  localparam int unsigned DLY_W         = 18;

  // Input deglitch times and their cycle counts (least times round up)
  localparam int unsigned T_PROJ_DGL_MS = 1;
  localparam int unsigned PROJ_DGL_CYC  = T_PROJ_DGL_MS * (CLK_HZ / 1000);
  localparam int unsigned T_SEL_DGL_NS  = 300;
  localparam int unsigned SEL_DGL_CYC   =
    (T_SEL_DGL_NS * CLK_MHZ + 999) / 1000;

  // Register byte offsets
  localparam logic [4:0] OFF_SWCTL  = 5'h00;
  localparam logic [4:0] OFF_GAP    = 5'h04;
  localparam logic [4:0] OFF_CODE_A = 5'h08;
  localparam logic [4:0] OFF_CODE_B = 5'h0c;
  localparam logic [4:0] OFF_CODE_C = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;

  // Values after reset
  localparam logic [2:0] SWCTL_RST = 3'h7;
  localparam logic [7:0] GAP_RST   = 8'h0a;
  localparam logic [9:0] CODE_RST  = 10'h000;

  // Status word fields
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_OFS       = 4;
  localparam int unsigned STS_BIAS      = 5;
  localparam int unsigned STS_RST       = 6;
  localparam int unsigned STS_STROBE    = 7;
  localparam int unsigned STS_SW_LSB    = 8;
  localparam int unsigned STS_FAULT     = 11;
  localparam int unsigned STS_RAIL_LSB  = 12;

  // Colour select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_A    = 2'h1;
  localparam logic [1:0] SEL_B    = 2'h2;
  localparam logic [1:0] SEL_C    = 2'h3;

  // Rail sequencer states
  typedef enum logic [2:0] {
    ST_OFF       = 3'h0,
    ST_INIT      = 3'h1,
    ST_OFS       = 3'h2,
    ST_ON        = 3'h3,
    ST_PD_PREP   = 3'h4,
    ST_PD        = 3'h5,
    ST_FAST_PREP = 3'h6,
    ST_FAST      = 3'h7
  } lsrs_state_e;

  // Colour select to switch mask, bit 0 is switch a
  function automatic logic [2:0] lsrs_sel_decode(input logic [1:0] sel);
    logic [2:0] m;
    m = 3'h0;
    if (sel == SEL_A) m = 3'h1;
    if (sel == SEL_B) m = 3'h2;
    if (sel == SEL_C) m = 3'h4;
    return m;
  endfunction

endpackage

// >>> logic/lsrs_deglitch.sv
// Input filter that passes a level only after it has held steady
`timescale 1ns/1ps
module lsrs_deglitch #(
  parameter int unsigned W   = 1,  // Width of the filtered bus
  parameter int unsigned CNT = 8   // Steady cycles before acceptance
) (
  input  wire logic         core_clk, // Core clock
  input  wire logic         sys_rst,  // Synchronous reset, high
  input  wire logic [W-1:0] din,      // Raw input level
  output logic      [W-1:0] dout      // Accepted level
);

  localparam int unsigned   CW   = $clog2(CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);

  logic [W-1:0]  cand_ff;
  logic [W-1:0]  nxt_cand;
  logic [W-1:0]  out_ff;
  logic [W-1:0]  nxt_out;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Any change restarts the count, so a glitch never leaks through
  always_comb begin
    nxt_cand = din;
    nxt_cnt  = cnt_ff;
    nxt_out  = out_ff;
    if (din != cand_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff != LAST) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else begin
      nxt_out = cand_ff;
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cand_ff <= '0;
      cnt_ff  <= '0;
      out_ff  <= '0;
    end else begin
      cand_ff <= nxt_cand;
      cnt_ff  <= nxt_cnt;
      out_ff  <= nxt_out;
    end
  end

  assign dout = out_ff;

  ////////////////////////////////////////////////////////////////////////////
  // A new level must have been seen on the two last samples
  a_filter_holds_level: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $changed(out_ff) |-> ($past(din) == out_ff && $past(din, 2) == out_ff))
    else $error("filtered level changed without a steady input");

endmodule

// >>> tb/lsrs_ctrl_model.sv
// Display controller model driving power request and colour select
`timescale 1ns/1ps
module lsrs_ctrl_model #(
  parameter int unsigned HOLD = 60 // Cycles each colour is held
) (
  input  wire logic       core_clk,                       // Core clock
  input  wire logic       sys_rst,                        // Sync reset
  input  wire logic       power_cmd,                      // Bench wants power
  input  wire logic       rotate,                         // Run rotation
  input  wire logic [1:0] sel_cmd,                        // Fixed colour
  output logic            projector_power_request = 1'b0, // To device
  output logic      [1:0] colour_select = 2'h0            // To device
);
  int unsigned hold_cnt;
  logic [1:0]  rot_sel;
  ////////////////////////////////////////////////////////////
  // Pins move only after an edge; hold far above the filter time
  always @(posedge core_clk) begin
    if (sys_rst || !rotate) begin
      hold_cnt <= 0;
      rot_sel  <= lsrs_pkg::SEL_A;
    end else if (hold_cnt == HOLD - 1) begin
      hold_cnt <= 0;
      rot_sel  <= (rot_sel == lsrs_pkg::SEL_C) ? lsrs_pkg::SEL_A
                                               : rot_sel + 2'h1;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
    projector_power_request <= !sys_rst && power_cmd;
    colour_select <= rotate ? rot_sel : sel_cmd;
  end
endmodule

// >>> tb/tb_lsrs_top.sv
// Self-checking bench for the rail sequencer and colour strobe
`timescale 1ns/1ps
module tb_lsrs_top;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        projector_power_request;
  logic [1:0]  colour_select;
  logic [2:0]  rail_fault = 3'h0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, mirror_init, offset_rail_en, bias_rail_en;
  logic        reset_rail_en, rail_discharge, led_driver_en;
  logic        switch_a, switch_b, switch_c;
  logic [9:0]  led_current_code;
  logic        pwr = 1'b0;
  logic        rot = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [8:0]  obs;
  logic [31:0] q;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n;
  logic [9:0]  code [3] = '{10'h101, 10'h202, 10'h303};
  ////////////////////////////////////////////////////////////
  // Outputs gathered so one wait task serves all of them
  assign obs = {switch_c, switch_b, switch_a, rail_discharge, led_driver_en,
                reset_rail_en, bias_rail_en, offset_rail_en, mirror_init};
  initial forever #20 core_clk = ~core_clk;
  lsrs_top #(.OFS_DLY_US(3), .RAIL_DLY_US(5), .PD_DLY_US(2), .PROJ_DGL_CYC(4))
    u_lsrs_top (.core_clk, .sys_rst, .projector_power_request, .colour_select,
    .rail_fault, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .mirror_init,
    .offset_rail_en, .bias_rail_en, .reset_rail_en, .rail_discharge,
    .led_driver_en, .switch_a, .switch_b, .switch_c, .led_current_code);
  lsrs_ctrl_model u_lsrs_ctrl_model (.core_clk, .sys_rst, .power_cmd(pwr),
    .rotate(rot), .sel_cmd(sel), .projector_power_request, .colour_select);
  ////////////////////////////////////////////////////////////
  // Verdict, comparisons, bus cycles and bounded waits
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(string nm, int lo, int hi, int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Request held until waitrequest is seen low; one idle edge after
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wt(int k, logic v);
    n = 0;
    while (obs[k] !== v && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 5000) begin
      bad_count++;
      $display("[FAIL] wait obs[%0d] expected %b seen timeout", k, v);
    end
  endtask
  task automatic power_up;
    pwr <= 1'b1;
    wt(0, 1'b1);
    wt(1, 1'b1);
    chk_rng("ofs delay", 48, 104, n);
    chk("early", 32'h0, {switch_a, led_driver_en, bias_rail_en});
    wt(2, 1'b1);
    chk_rng("rail delay", 98, 154, n);
    chk("rails on", 32'h3, {reset_rail_en, led_driver_en});
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk("reset", 32'h1, {led_current_code, obs, avs_waitrequest});
    bus(0, lsrs_pkg::OFF_SWCTL, 0);
    chk("swctl", 32'h7, q);
    bus(0, lsrs_pkg::OFF_GAP, 0);
    chk("gap", 32'ha, q);
    bus(1, 5'h18, 32'hff);
    bus(0, 5'h18, 0);
    chk("unmapped", 32'h0, q);
    bus(1, lsrs_pkg::OFF_GAP, 3);
    for (int i = 0; i < 3; i++) begin
      bus(1, 5'(lsrs_pkg::OFF_CODE_A + 4 * i), code[i]);
      bus(0, 5'(lsrs_pkg::OFF_CODE_A + 4 * i), 0);
      chk("code reg", code[i], q);
    end
    pwr <= 1'b1;
    repeat (2) @(posedge core_clk);
    pwr <= 1'b0;
    repeat (10) begin
      @(posedge core_clk);
      chk("glitch pwr", 32'h0, mirror_init);
    end
    power_up;
    rot <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wt(6 + i % 3, 1'b1);
      chk("code", code[i % 3], led_current_code);
      chk("one hot", 32'h1 << (i % 3), {switch_c, switch_b, switch_a});
      if (i < 3) begin
        wt(6 + i % 3, 1'b0);
        chk("break", 32'h0, {led_current_code, obs[8:6]});
        wt(6 + (i + 1) % 3, 1'b1);
        chk("dead time", 32'h3, n);
      end
    end
    rot <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk("none", 32'h0, {led_current_code, obs[8:6]});
    sel <= lsrs_pkg::SEL_B;
    repeat (20) @(posedge core_clk);
    sel <= lsrs_pkg::SEL_C;
    repeat (4) @(posedge core_clk);
    sel <= lsrs_pkg::SEL_B;
    repeat (20) begin
      @(posedge core_clk);
      chk("glitch sel", 32'h2, obs[8:6]);
    end
    bus(1, lsrs_pkg::OFF_SWCTL, 6);
    @(posedge core_clk);
    chk("stay closed", 32'h2, obs[8:6]);
    rail_fault <= 3'h4;
    wt(4, 1'b0);
    wt(7, 1'b0);
    chk("rails held", 32'h7, obs[3:1]);
    wt(5, 1'b1);
    chk("discharge", 32'h0, obs[3:1]);
    bus(0, lsrs_pkg::OFF_STATUS, 0);
    chk("status", 32'h4807, q);
    rail_fault <= 3'h0;
    pwr <= 1'b0;
    repeat (30) @(posedge core_clk);
    power_up;
    pwr <= 1'b0;
    wt(2, 1'b0);
    chk("pd order", 32'h1, {rail_discharge, led_driver_en, offset_rail_en});
    wt(1, 1'b0);
    chk_rng("pd delay", 24, 78, n);
    end_of_test;
  end
endmodule
